//--- nstr_pkg.sv
package nstr_pkg;

    // register offsets
    localparam logic [7:0] OFF_TARGET_STATE = 8'h21;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h22;
    localparam logic [7:0] OFF_COUNT_LOW_BITS = 8'h23;
    localparam logic [7:0] OFF_RATE_TIMERS = 8'h24;
    localparam logic [7:0] OFF_CONV_RESULT = 8'h25;
    localparam logic [7:0] OFF_DAC_A = 8'h26;
    localparam logic [7:0] OFF_DAC_B = 8'h27;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h31;

    // values after reset
    localparam logic [7:0] RST_DAC_CODE = 8'h80;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // passive target state codes
    localparam logic [3:0] TGT_POWER_OFF = 4'h0;
    localparam logic [3:0] TGT_IDLE = 4'h1;
    localparam logic [3:0] TGT_READY_L1 = 4'h2;
    localparam logic [3:0] TGT_READY_L2 = 4'h3;
    localparam logic [3:0] TGT_ACTIVE = 4'h5;
    localparam logic [3:0] TGT_HALT = 4'h9;
    localparam logic [3:0] TGT_READY_L1_STAR = 4'hA;
    localparam logic [3:0] TGT_READY_L2_STAR = 4'hB;
    localparam logic [3:0] TGT_ACTIVE_STAR = 4'hD;

    // interrupt status bit positions
    localparam int unsigned IRQ_PAR_BIT = 0;
    localparam int unsigned IRQ_ACTIVE_BIT = 1;
    localparam int unsigned IRQ_ADC_BIT = 2;
    localparam logic [2:0] IRQ_USED = 3'h7;

    // largest byte count the counter holds
    localparam logic [12:0] TX_COUNT_MAX = 13'h1FFF;

    // register bus request, one cycle per strobe
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nstr_bus_req_t;

    // timer activity, bit order as displayed
    typedef struct packed {
        logic ppon2_timer_running;
        logic gp_timer_running;
        logic no_response_timer_running;
        logic mask_receive_timer_running;
    } nstr_timers_t;

    // trailing bit stream toward the modulator
    typedef struct packed {
        logic bit_value;
        logic valid;
        logic done;
    } nstr_tail_t;

    // trailing bit serializer states
    typedef enum logic [1:0] {
        TAIL_IDLE = 2'b01,
        TAIL_SHIFT = 2'b10
    } nstr_tail_state_t;

endpackage

//--- nstr_regs.sv
// The strobed register port was left to the implementer.
module nstr_regs
(
    input wire logic clock,
    input wire logic rst,
    input wire nstr_pkg::nstr_bus_req_t bus,
    output logic [7:0] rdata,
    input wire logic [3:0] target_state,
    input wire logic bitrate_detect_mode,
    input wire logic [1:0] detected_rate,
    input wire nstr_pkg::nstr_timers_t timers,
    input wire logic [7:0] adc_result,
    input wire logic adc_valid,
    input wire logic anticoll_enable,
    input wire logic reqa_cmd,
    input wire logic wupa_cmd,
    input wire logic iso_a_mode,
    input wire logic iso_b_mode,
    input wire logic tx_no_crc_cmd,
    input wire logic tail_start,
    input wire logic [7:0] tail_byte,
    output logic [12:0] tx_byte_count,
    output logic [2:0] tail_bit_count,
    output logic tail_parity_enable,
    output logic short_frame_allowed,
    output nstr_pkg::nstr_tail_t tail,
    output logic [7:0] dac_a_code,
    output logic [7:0] dac_b_code,
    output logic irq
);
    import nstr_pkg::*;

    // display and interrupt state
    logic [7:0] conversion_result; // latest converter sample
    logic [2:0] irq_status; // sticky event bits
    logic [2:0] irq_mask; // one enables the bit
    logic [2:0] next_irq_status; // status after this cycle
    logic was_active; // target was in an active state
    logic par_event; // parity interrupt cause
    logic active_event; // target just became active
    logic status_read; // read of the status register

    // trailing bit serializer
    nstr_tail_state_t tail_state;
    logic [7:0] tail_shift; // bits still to send, lsb next
    logic [2:0] tail_left; // bits still to send
    logic tail_go; // start accepted

    // active or active-star decode
    function automatic logic is_active(input logic [3:0] code);
        is_active = (code == TGT_ACTIVE) || (code == TGT_ACTIVE_STAR);
    endfunction

    // address match for a strobe
    function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                 input logic [7:0] off);
        hit = strobe && (addr == off);
    endfunction

    // short frames need iso-a or iso-b and the no-crc command
    assign short_frame_allowed = (iso_a_mode || iso_b_mode) && tx_no_crc_cmd;

    // parity generation off whenever the last byte is split
    assign tail_parity_enable = (tail_bit_count == 3'h0);

    // anticollision setup with partial bits on a reqa or wupa
    assign par_event = anticoll_enable && (target_state == TGT_IDLE)
                       && (tail_bit_count != 3'h0) && (reqa_cmd || wupa_cmd);

    // host must take over once the target enters an active state
    assign active_event = is_active(target_state) && !was_active;

    // status clears on its own read
    assign status_read = hit(bus.rd, bus.addr, OFF_IRQ_STATUS);

    // set wins over the read clear
    always_comb
    begin
        next_irq_status = status_read ? 3'h0 : irq_status;
        if (par_event)
        begin
            next_irq_status[IRQ_PAR_BIT] = 1'b1;
        end
        if (active_event)
        begin
            next_irq_status[IRQ_ACTIVE_BIT] = 1'b1;
        end
        if (adc_valid)
        begin
            next_irq_status[IRQ_ADC_BIT] = 1'b1;
        end
    end

    // level interrupt from unmasked status
    assign irq = |(irq_status & irq_mask);

    // sticky status and active edge tracking
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            irq_status <= 3'h0;
            was_active <= 1'b0;
        end
        else
        begin
            irq_status <= next_irq_status;
            was_active <= is_active(target_state);
        end
    end

    // transmit byte count and trailing bit count
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tx_byte_count <= {RST_ZERO, RST_ZERO[4:0]};
            tail_bit_count <= RST_ZERO[2:0];
        end
        else if (hit(bus.wr, bus.addr, OFF_COUNT_HIGH))
        begin
            // upper eight count bits
            tx_byte_count[12:5] <= bus.wdata;
        end
        else if (hit(bus.wr, bus.addr, OFF_COUNT_LOW_BITS))
        begin
            // lower five count bits and the extra bit count
            tx_byte_count[4:0] <= bus.wdata[7:3];
            tail_bit_count <= bus.wdata[2:0];
        end
    end

    // tuning dac codes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            dac_a_code <= RST_DAC_CODE;
            dac_b_code <= RST_DAC_CODE;
        end
        else if (hit(bus.wr, bus.addr, OFF_DAC_A))
        begin
            dac_a_code <= bus.wdata;
        end
        else if (hit(bus.wr, bus.addr, OFF_DAC_B))
        begin
            dac_b_code <= bus.wdata;
        end
    end

    // interrupt mask
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            irq_mask <= RST_ZERO[2:0];
        end
        else if (hit(bus.wr, bus.addr, OFF_IRQ_MASK))
        begin
            irq_mask <= bus.wdata[2:0] & IRQ_USED;
        end
    end

    // latest conversion, host writes have no effect
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            conversion_result <= RST_ZERO;
        end
        else if (adc_valid)
        begin
            conversion_result <= adc_result;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdata <= RST_ZERO;
        end
        else if (!bus.rd)
        begin
            rdata <= RST_ZERO;
        end
        else if (bus.addr == OFF_TARGET_STATE)
        begin
            // state code, upper nibble reserved
            rdata <= {4'h0, target_state};
        end
        else if (bus.addr == OFF_COUNT_HIGH)
        begin
            rdata <= tx_byte_count[12:5];
        end
        else if (bus.addr == OFF_COUNT_LOW_BITS)
        begin
            rdata <= {tx_byte_count[4:0], tail_bit_count};
        end
        else if (bus.addr == OFF_RATE_TIMERS)
        begin
            // rate only meaningful in detection mode
            rdata <= {2'h0, bitrate_detect_mode ? detected_rate : 2'h0,
                      timers};
        end
        else if (bus.addr == OFF_CONV_RESULT)
        begin
            rdata <= conversion_result;
        end
        else if (bus.addr == OFF_DAC_A)
        begin
            rdata <= dac_a_code;
        end
        else if (bus.addr == OFF_DAC_B)
        begin
            rdata <= dac_b_code;
        end
        else if (bus.addr == OFF_IRQ_STATUS)
        begin
            rdata <= {5'h00, irq_status};
        end
        else if (bus.addr == OFF_IRQ_MASK)
        begin
            rdata <= {5'h00, irq_mask};
        end
        else
        begin
            // unmapped reads as zero
            rdata <= RST_ZERO;
        end
    end

    // start only with a split byte on an allowed frame
    assign tail_go = tail_start && (tail_state == TAIL_IDLE)
                     && (tail_bit_count != 3'h0) && short_frame_allowed;

    // trailing bits shifted out lsb first, no parity slot after
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tail_state <= TAIL_IDLE;
            tail_shift <= RST_ZERO;
            tail_left <= 3'h0;
            tail <= '0;
        end
        else
        begin
            case (tail_state)
                TAIL_IDLE:
                begin
                    tail <= '0;
                    if (tail_go)
                    begin
                        // capture byte and bit count
                        tail_shift <= tail_byte;
                        tail_left <= tail_bit_count;
                        tail_state <= TAIL_SHIFT;
                    end
                end
                TAIL_SHIFT:
                begin
                    // emit current lsb
                    tail.bit_value <= tail_shift[0];
                    tail.valid <= 1'b1;
                    tail_shift <= {1'b0, tail_shift[7:1]};
                    tail_left <= tail_left - 3'h1;
                    if (tail_left == 3'h1)
                    begin
                        // last bit, return without a parity bit
                        tail.done <= 1'b1;
                        tail_state <= TAIL_IDLE;
                    end
                    else
                    begin
                        tail.done <= 1'b0;
                    end
                end
                default:
                begin
                    tail_state <= TAIL_IDLE;
                end
            endcase
        end
    end

    // checks on the register and serializer behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_state_read;
        hit(bus.rd, bus.addr, OFF_TARGET_STATE) |=> rdata == {4'h0, $past(target_state)};
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("target state read wrong");

    property p_count_high;
        hit(bus.wr, bus.addr, OFF_COUNT_HIGH) |=> tx_byte_count[12:5] == $past(bus.wdata);
    endproperty
    a_count_high: assert property (p_count_high)
        else $error("count high not written");

    property p_count_low;
        hit(bus.wr, bus.addr, OFF_COUNT_LOW_BITS) |=>
            tail_bit_count == $past(bus.wdata[2:0]) &&
            tx_byte_count[4:0] == $past(bus.wdata[7:3]);
    endproperty
    a_count_low: assert property (p_count_low)
        else $error("count low or bit count not written");

    property p_tail_lsb;
        tail_go |-> ##2 tail.valid && tail.bit_value == $past(tail_byte[0], 2);
    endproperty
    a_tail_lsb: assert property (p_tail_lsb)
        else $error("first trailing bit not lsb");

    property p_tail_one;
        tail_go && tail_bit_count == 3'h1 |-> ##2 tail.done ##1 !tail.valid;
    endproperty
    a_tail_one: assert property (p_tail_one)
        else $error("extra bit after split byte");

    property p_no_parity;
        tail_bit_count != 3'h0 |-> !tail_parity_enable;
    endproperty
    a_no_parity: assert property (p_no_parity)
        else $error("parity enabled on split byte");

    property p_par_irq;
        par_event |=> irq_status[IRQ_PAR_BIT] ##1 (irq_status[IRQ_PAR_BIT] || $past(status_read));
    endproperty
    a_par_irq: assert property (p_par_irq)
        else $error("parity interrupt not raised");

    property p_short_refused;
        tail_start && tail_state == TAIL_IDLE && !short_frame_allowed |=> ##1 !tail.valid;
    endproperty
    a_short_refused: assert property (p_short_refused)
        else $error("short frame sent outside allowed mode");

    property p_rate_read;
        hit(bus.rd, bus.addr, OFF_RATE_TIMERS) |=>
            rdata[5:4] == ($past(bitrate_detect_mode) ? $past(detected_rate) : 2'h0)
            && rdata[7:6] == 2'h0;
    endproperty
    a_rate_read: assert property (p_rate_read)
        else $error("bit rate display wrong");

    property p_timer_read;
        hit(bus.rd, bus.addr, OFF_RATE_TIMERS) |=> rdata[3:0] == $past(timers);
    endproperty
    a_timer_read: assert property (p_timer_read)
        else $error("timer flags wrong");

    property p_adc_read;
        adc_valid ##1 (hit(bus.rd, bus.addr, OFF_CONV_RESULT) && !adc_valid)
            |=> rdata == $past(adc_result, 2);
    endproperty
    a_adc_read: assert property (p_adc_read)
        else $error("conversion result wrong");

    property p_dac_a;
        hit(bus.wr, bus.addr, OFF_DAC_A) |=> dac_a_code == $past(bus.wdata);
    endproperty
    a_dac_a: assert property (p_dac_a)
        else $error("dac a code not written");

    property p_dac_b;
        hit(bus.wr, bus.addr, OFF_DAC_B) |=> dac_b_code == $past(bus.wdata);
    endproperty
    a_dac_b: assert property (p_dac_b)
        else $error("dac b code not written");

    property p_ro_ignore;
        hit(bus.wr, bus.addr, OFF_CONV_RESULT) && !adc_valid |=> $stable(conversion_result);
    endproperty
    a_ro_ignore: assert property (p_ro_ignore)
        else $error("read-only register changed by write");

    // main scenarios
    c_tail_done: cover property (tail_go ##[2:9] tail.done);
    c_par_irq: cover property (par_event ##1 irq);
    c_status_clear: cover property (irq ##1 status_read ##1 !irq);
    c_active_enter: cover property (active_event);

endmodule // nstr_regs

//--- nstr_regs_test.sv
module nstr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import nstr_pkg::*;

    logic clock; // 100 MHz
    logic rst; // async, active high
    nstr_bus_req_t bus; // register strobes
    logic [7:0] rdata;
    logic [3:0] target_state;
    logic bitrate_detect_mode;
    logic [1:0] detected_rate;
    nstr_timers_t timers;
    logic [7:0] adc_result;
    logic adc_valid;
    logic anticoll_enable;
    logic reqa_cmd;
    logic wupa_cmd;
    logic iso_a_mode;
    logic iso_b_mode;
    logic tx_no_crc_cmd;
    logic tail_start;
    logic [7:0] tail_byte;
    logic [12:0] tx_byte_count;
    logic [2:0] tail_bit_count;
    logic tail_parity_enable;
    logic short_frame_allowed;
    nstr_tail_t tail;
    logic [7:0] dac_a_code;
    logic [7:0] dac_b_code;
    logic irq;
    int n_fail; // mismatches
    int cmp_count; // comparisons
    logic [7:0] bits; // captured tail bits
    int nb; // captured tail bit count
    logic last_done; // done seen with last bit
    // every documented state code
    logic [3:0] codes [9] = '{TGT_POWER_OFF, TGT_IDLE, TGT_READY_L1, TGT_READY_L2, TGT_ACTIVE,
        TGT_HALT, TGT_READY_L1_STAR, TGT_READY_L2_STAR, TGT_ACTIVE_STAR};

    nstr_regs i_dut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
        .target_state(target_state), .bitrate_detect_mode(bitrate_detect_mode),
        .detected_rate(detected_rate), .timers(timers), .adc_result(adc_result),
        .adc_valid(adc_valid), .anticoll_enable(anticoll_enable), .reqa_cmd(reqa_cmd),
        .wupa_cmd(wupa_cmd), .iso_a_mode(iso_a_mode), .iso_b_mode(iso_b_mode),
        .tx_no_crc_cmd(tx_no_crc_cmd), .tail_start(tail_start), .tail_byte(tail_byte),
        .tx_byte_count(tx_byte_count), .tail_bit_count(tail_bit_count),
        .tail_parity_enable(tail_parity_enable), .short_frame_allowed(short_frame_allowed),
        .tail(tail), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code), .irq(irq));

    // clock generator
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // compare and count
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            n_fail++;
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
    endtask

    // one-cycle read strobe, data in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        bus <= '0;
        #1;
        d = rdata;
    endtask

    // read and compare
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(nm, {8'h00, d}, {8'h00, exp});
    endtask

    // start the trailing byte and capture what comes out
    task automatic tail_run(input logic [7:0] b);
        @(posedge clock);
        tail_byte <= b;
        tail_start <= 1'b1;
        @(posedge clock);
        tail_start <= 1'b0;
        nb = 0;
        bits = 8'h00;
        last_done = 1'b0;
        repeat (12)
        begin
            @(posedge clock);
            #1;
            if (tail.valid === 1'b1)
            begin
                bits[nb] = tail.bit_value;
                last_done = tail.done;
                nb++;
            end
        end
    endtask

    // one-cycle direct command pulse
    task automatic cmd_pulse(input bit use_wupa);
        @(posedge clock);
        reqa_cmd <= !use_wupa;
        wupa_cmd <= use_wupa;
        @(posedge clock);
        reqa_cmd <= 1'b0;
        wupa_cmd <= 1'b0;
        #1;
    endtask

    // counts and verdict
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard, well above the test length
    initial
    begin
        repeat (5000) @(posedge clock);
        n_fail++;
        summarize();
    end

    // main sequence
    initial
    begin
        n_fail = 0;
        cmp_count = 0;
        rst = 1'b1;
        bus = '0;
        target_state = TGT_POWER_OFF;
        bitrate_detect_mode = 1'b0;
        detected_rate = 2'h0;
        timers = '0;
        adc_result = 8'h00;
        adc_valid = 1'b0;
        anticoll_enable = 1'b0;
        reqa_cmd = 1'b0;
        wupa_cmd = 1'b0;
        iso_a_mode = 1'b0;
        iso_b_mode = 1'b0;
        tx_no_crc_cmd = 1'b0;
        tail_start = 1'b0;
        tail_byte = 8'h00;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        // reset values
        #1;
        chk("dac_a_code", dac_a_code, RST_DAC_CODE);
        chk("dac_b_code", dac_b_code, RST_DAC_CODE);
        chk("tx_byte_count", tx_byte_count, 16'h0000);
        chk("tail_bit_count", tail_bit_count, 16'h0000);
        chk("parity_enable", tail_parity_enable, 16'h0001);
        rchk("count_high", OFF_COUNT_HIGH, 8'h00);
        rchk("count_low", OFF_COUNT_LOW_BITS, 8'h00);
        rchk("dac_a", OFF_DAC_A, 8'h80);
        rchk("dac_b", OFF_DAC_B, 8'h80);
        rchk("unmapped", 8'h40, 8'h00);
        // every state code, reserved high nibble zero
        foreach (codes[i])
        begin
            @(posedge clock);
            target_state <= codes[i];
            rchk("state", OFF_TARGET_STATE, {4'h0, codes[i]});
        end
        // writes to read-only places ignored
        wr(OFF_TARGET_STATE, 8'hFF);
        rchk("state_ro", OFF_TARGET_STATE, {4'h0, TGT_ACTIVE_STAR});
        // largest count, split across two registers
        wr(OFF_COUNT_HIGH, 8'hFF);
        wr(OFF_COUNT_LOW_BITS, 8'hFF);
        #1;
        chk("tx_byte_count", tx_byte_count, 16'h1FFF);
        chk("tail_bit_count", tail_bit_count, 16'h0007);
        chk("parity_enable", tail_parity_enable, 16'h0000);
        wr(OFF_COUNT_LOW_BITS, 8'h03);
        #1;
        chk("tx_byte_count", tx_byte_count, 16'h1FE0);
        rchk("count_low", OFF_COUNT_LOW_BITS, 8'h03);
        // rate and timers, in and out of detection mode
        @(posedge clock);
        bitrate_detect_mode <= 1'b1;
        detected_rate <= 2'h3;
        timers <= 4'hA;
        rchk("rate_timers", OFF_RATE_TIMERS, 8'h3A);
        @(posedge clock);
        detected_rate <= 2'h2;
        timers <= 4'h5;
        rchk("rate_timers", OFF_RATE_TIMERS, 8'h25);
        @(posedge clock);
        bitrate_detect_mode <= 1'b0;
        rchk("timers_only", OFF_RATE_TIMERS, 8'h05);
        wr(OFF_RATE_TIMERS, 8'hFF);
        rchk("timers_ro", OFF_RATE_TIMERS, 8'h05);
        // conversion result, read only
        @(posedge clock);
        adc_result <= 8'h5A;
        adc_valid <= 1'b1;
        // read strobe right after the one-cycle sample pulse
        fork
            rchk("conv", OFF_CONV_RESULT, 8'h5A);
            begin
                @(posedge clock);
                adc_valid <= 1'b0;
                adc_result <= 8'hC3;
            end
        join
        wr(OFF_CONV_RESULT, 8'h00);
        rchk("conv_ro", OFF_CONV_RESULT, 8'h5A);
        // masked events raise no interrupt, status read clears
        chk("irq_masked", irq, 16'h0000);
        rchk("irq_status", OFF_IRQ_STATUS, 8'h06);
        rchk("irq_cleared", OFF_IRQ_STATUS, 8'h00);
        // tuning codes at both ends of the range
        wr(OFF_DAC_A, 8'h00);
        wr(OFF_DAC_B, 8'hFF);
        #1;
        chk("dac_a_code", dac_a_code, 16'h0000);
        chk("dac_b_code", dac_b_code, 16'h00FF);
        rchk("dac_b", OFF_DAC_B, 8'hFF);
        // short frame permission for all mode mixes
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock);
            iso_a_mode <= i[0];
            iso_b_mode <= i[1];
            tx_no_crc_cmd <= i[2];
            #1;
            chk("short_frame", short_frame_allowed, 16'((i[0] | i[1]) & i[2]));
        end
        // withdraw the no-crc command so short frames are not allowed
        @(posedge clock);
        tx_no_crc_cmd <= 1'b0;
        #1;
        chk("short_frame_off", short_frame_allowed, 16'h0000);
        // tail refused while no frame allowed
        tail_run(8'hB5);
        chk("tail_refused", nb, 16'h0000);
        @(posedge clock);
        iso_a_mode <= 1'b1;
        tx_no_crc_cmd <= 1'b1;
        // three bits, lsb first, no parity bit after
        tail_run(8'hB5);
        chk("tail_nbits", nb, 16'h0003);
        chk("tail_bits", bits, 16'h0005);
        chk("tail_done", last_done, 16'h0001);
        // a single trailing bit, done with it
        wr(OFF_COUNT_LOW_BITS, 8'h01);
        tail_run(8'hFE);
        chk("tail_nbits1", nb, 16'h0001);
        chk("tail_bits1", bits, 16'h0000);
        chk("tail_done1", last_done, 16'h0001);
        // count zero refuses the tail
        wr(OFF_COUNT_LOW_BITS, 8'h00);
        tail_run(8'hFF);
        chk("tail_zero", nb, 16'h0000);
        // parity interrupt on both direct commands
        wr(OFF_COUNT_LOW_BITS, 8'h03);
        wr(OFF_IRQ_MASK, 8'h01);
        @(posedge clock);
        target_state <= TGT_IDLE;
        anticoll_enable <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            cmd_pulse(k[0]);
            chk("irq_par", irq, 16'h0001);
            rchk("irq_status", OFF_IRQ_STATUS, 8'h01);
            chk("irq_clear", irq, 16'h0000);
        end
        // no parity interrupt without anticollision
        @(posedge clock);
        anticoll_enable <= 1'b0;
        cmd_pulse(1'b0);
        chk("irq_noanti", irq, 16'h0000);
        // no parity interrupt with count zero
        @(posedge clock);
        anticoll_enable <= 1'b1;
        wr(OFF_COUNT_LOW_BITS, 8'h00);
        cmd_pulse(1'b1);
        chk("irq_nobits", irq, 16'h0000);
        summarize();
    end
endmodule // nstr_regs_test
